/* File: rtl/pwm_timer.v */
// Paired 8-bit timer in PWM output mode, with an APB slave for its registers.
// Assumes a single 125 MHz clock, an APB master on that clock and an external pin on timer_output_pin.
`timescale 1ns/1ps
`include "pwm_timer_defines.vh"

// Notes on behaviour
// - PWM mode exists only on the low-order channel, up to 8-bit resolution.
// - PWM waveform is driven on the timer output pin, shared with a port bit.
// - High-order channel stays usable as an independent 8-bit interval timer.
// - Output flip-flop toggles when low counter equals low compare register.
// - Output flip-flop also toggles at the 2^n-1 overflow, n of 6, 7 or 8.
// - Each 2^n-1 overflow clears the low counter to zero.
// - With double buffering, the buffered compare loads at each overflow.
// - Mode bits 7:6 = 11 PWM, 5:4 period, 1:0 low clock tap.
// - Run bit 0 cleared stops and clears low counter; bits 2,0 start it.
// - Control bits 3:2 = 10 clear the flip-flop; bit 1 enables toggling.
// - In PWM mode the high counter ignores the low match and drives no pin; high_match_o still pulses.
module pwm_timer #(
	// Nine bits let the slowest tap run 256 times slower than the fastest.
	parameter DIV_W = 9
) (
	// Clock and reset
	input wire clk_i,
	input wire sys_rst_i,
	// External clock input for the low channel, tap 00
	input wire ext_clk_i,
	// Port data when the pin is a plain port
	input wire port_data_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	// Pin
	output reg timer_output_pin_o,
	output reg timer_output_pin_oe_o,
	// High channel match pulse
	output reg high_match_o
);
	reg [7:0] pair_run_reg;
	reg [7:0] pair_mode_reg;
	reg [7:0] low_compare_reg;
	reg [7:0] low_compare_buf_reg;
	reg [7:0] high_compare_reg;
	reg [7:0] flip_flop_control_reg;
	reg [7:0] port_direction_reg;
	reg [7:0] port_function_reg;
	reg [7:0] low_up_counter;
	reg [7:0] high_up_counter;
	reg output_flip_flop;
	reg [DIV_W-1:0] prescale_reg;
	reg prescale_d_reg;
	reg [3:0] prescale_prev_reg;
	reg ext_s1_reg;
	reg ext_s2_reg;
	reg ext_s3_reg;
	wire low_run;
	wire high_run;
	wire pwm_mode;
	wire wr_en;
	wire rd_en;
	wire [3:0] taps;
	wire [3:0] tap_rise;
	wire ext_rise;
	reg low_tick;
	reg high_tick;
	wire [7:0] overflow_val;
	wire [7:0] low_count_next;
	wire [7:0] high_count_next;
	wire low_match;
	wire overflow;
	wire high_hit;
	wire wr_cmp;
	wire wr_ffcr;
	wire [1:0] ff_cmd;
	reg [31:0] rd_data;

	// Both channels step their counters the same way; the carry out of bit 7 is dropped on purpose,
	// so that a compare of zero on the high channel means a full 256-tick interval.
	function [7:0] next_count;
		input [7:0] c;
		begin
			next_count = c + 8'h01;
		end
	endfunction

	// Top count of the PWM period; the undefined code 00 falls back to the full eight bits.
	function [7:0] period_top;
		input [1:0] sel;
		begin
			case (sel)
				`PERIOD_6: period_top = `TOP_6;
				`PERIOD_7: period_top = `TOP_7;
				default: period_top = `TOP_8;
			endcase
		end
	endfunction

	function addr_known;
		input [11:0] a;
		begin
			addr_known = (a == `OFF_RUN) || (a == `OFF_MODE) || (a == `OFF_LOW_CMP) ||
				(a == `OFF_HIGH_CMP) || (a == `OFF_FFCR) || (a == `OFF_STATUS) ||
				(a == `OFF_PORT_DIR) || (a == `OFF_PORT_FUNC) || (a == `OFF_DBUF);
		end
	endfunction

	// A transfer is taken once, at its first access edge; the pready pulse that follows blocks a second take.
	assign wr_en = psel_i && penable_i && pwrite_i && !pready_o;
	assign rd_en = psel_i && penable_i && !pwrite_i && !pready_o;
	assign low_run = pair_run_reg[`RUN_LOW_BIT] && pair_run_reg[`RUN_PRESCALE_BIT];
	assign high_run = pair_run_reg[`RUN_HIGH_BIT] && pair_run_reg[`RUN_PRESCALE_BIT];
	assign pwm_mode = (pair_mode_reg[`MODE_SEL_HI:`MODE_SEL_LO] == `MODE_PWM);

	// Prescaler: taps div1, div4, div16 and div256 of the prescale clock, edge-detected to one-cycle ticks.
	// The prescaler steps every second clock, so the div1 tap ticks every fourth clock.
	// That keeps even the fastest tap below half the system clock, which a single clock needs to count safely.
	assign taps = {prescale_reg[DIV_W-1], prescale_reg[4], prescale_reg[2], prescale_reg[0]};
	assign tap_rise = taps & ~prescale_prev_reg;
	assign ext_rise = ext_s2_reg && !ext_s3_reg;

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prescale_reg <= {DIV_W{1'b0}};
			prescale_d_reg <= 1'b0;
			prescale_prev_reg <= 4'h0;
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			prescale_d_reg <= ~prescale_d_reg;
			if (!pair_run_reg[`RUN_PRESCALE_BIT]) begin
				prescale_reg <= {DIV_W{1'b0}};
			end else if (prescale_d_reg) begin
				prescale_reg <= prescale_reg + {{(DIV_W-1){1'b0}}, 1'b1};
			end
			prescale_prev_reg <= taps;
			// Two flops bring the external clock into this domain; the third only marks its rising edge.
			ext_s1_reg <= ext_clk_i;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	// Tap selection per channel; the high channel's code 00 borrows the low match outside PWM mode.
	always @* begin
		case (pair_mode_reg[`LCLK_HI:`LCLK_LO])
			2'h0: low_tick = ext_rise;
			2'h1: low_tick = tap_rise[0];
			2'h2: low_tick = tap_rise[1];
			default: low_tick = tap_rise[2];
		endcase
		// In PWM mode the code 00 would be the low match; it is not a legal source then.
		case (pair_mode_reg[`HCLK_HI:`HCLK_LO])
			2'h0: high_tick = pwm_mode ? 1'b0 : low_match;
			2'h1: high_tick = tap_rise[0];
			2'h2: high_tick = tap_rise[2];
			default: high_tick = tap_rise[3];
		endcase
	end

	// Matches look at the value that the counter takes on this tick. A compare of C thus toggles C ticks
	// after the overflow, and the counter never shows 2^n-1: it clears on reaching it, so a period is
	// 2^n-1 ticks. The high channel repeats every compare ticks in the same way.
	assign overflow_val = period_top(pair_mode_reg[`PERIOD_HI:`PERIOD_LO]);
	assign low_count_next = next_count(low_up_counter);
	assign high_count_next = next_count(high_up_counter);
	assign low_match = low_run && low_tick && (low_count_next == low_compare_reg);
	assign overflow = low_run && low_tick && pwm_mode && (low_count_next == overflow_val);
	assign high_hit = high_run && high_tick && (high_count_next == high_compare_reg);
	assign wr_cmp = wr_en && (paddr_i == `OFF_LOW_CMP);
	assign wr_ffcr = wr_en && (paddr_i == `OFF_FFCR);
	assign ff_cmd = pwdata_i[`FF_CMD_HI:`FF_CMD_LO];

	// Counters.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			low_up_counter <= 8'h00;
			high_up_counter <= 8'h00;
		end else begin
			if (!low_run) begin
				low_up_counter <= 8'h00;
			end else if (overflow) begin
				low_up_counter <= 8'h00;
			end else if (low_tick) begin
				low_up_counter <= low_count_next;
			end
			// The high channel is a plain interval timer; the PWM overflow never touches it.
			if (!high_run) begin
				high_up_counter <= 8'h00;
			end else if (high_hit) begin
				high_up_counter <= 8'h00;
			end else if (high_tick) begin
				high_up_counter <= high_count_next;
			end
		end
	end

	// Output flip-flop; software commands win over a timer toggle in the same cycle.
	// A match on the overflow tick would cancel out, which is why software keeps the compare below the top.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			output_flip_flop <= 1'b0;
		end else if (wr_ffcr && ff_cmd == `FF_CMD_CLEAR) begin
			output_flip_flop <= 1'b0;
		end else if (wr_ffcr && ff_cmd == `FF_CMD_SET) begin
			output_flip_flop <= 1'b1;
		end else if (wr_ffcr && ff_cmd == `FF_CMD_INVERT) begin
			output_flip_flop <= ~output_flip_flop;
		end else if (low_run && flip_flop_control_reg[`FF_TOGGLE_EN_BIT] && pwm_mode && (low_match ^ overflow)) begin
			output_flip_flop <= ~output_flip_flop;
		end
	end

	// Registers and APB slave; every access completes after one wait state.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pair_run_reg <= `RESET_BYTE;
			pair_mode_reg <= `RESET_BYTE;
			low_compare_reg <= `RESET_BYTE;
			low_compare_buf_reg <= `RESET_BYTE;
			high_compare_reg <= `RESET_BYTE;
			flip_flop_control_reg <= `RESET_FFCR;
			port_direction_reg <= `RESET_BYTE;
			port_function_reg <= `RESET_BYTE;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end else begin
			pready_o <= psel_i && penable_i && !pready_o;
			// An unmapped address is refused with pslverr, and a write to it changes nothing.
			pslverr_o <= (wr_en || rd_en) && !addr_known(paddr_i);
			prdata_o <= rd_en ? rd_data : 32'h00000000;
			if (wr_en) begin
				case (paddr_i)
					`OFF_RUN: pair_run_reg <= pwdata_i[7:0];
					`OFF_MODE: pair_mode_reg <= pwdata_i[7:0];
					`OFF_HIGH_CMP: high_compare_reg <= pwdata_i[7:0];
					`OFF_FFCR: flip_flop_control_reg <= {4'h0, 2'h3, pwdata_i[1:0]};
					`OFF_PORT_DIR: port_direction_reg <= pwdata_i[7:0];
					`OFF_PORT_FUNC: port_function_reg <= pwdata_i[7:0];
					default: ;
				endcase
			end
			// Buffered compare writes land in the buffer; a write in the overflow cycle goes straight to the compare.
			// With double buffering off, a compare write lands in the buffer and the compare at once.
			if (wr_cmp) begin
				low_compare_buf_reg <= pwdata_i[7:0];
			end
			if (pair_run_reg[`RUN_DBUF_BIT] && pwm_mode && overflow) begin
				low_compare_reg <= wr_cmp ? pwdata_i[7:0] : low_compare_buf_reg;
			end else if (wr_cmp && !pair_run_reg[`RUN_DBUF_BIT]) begin
				low_compare_reg <= pwdata_i[7:0];
			end
		end
	end

	always @* begin
		rd_data = 32'h00000000;
		case (paddr_i)
			`OFF_RUN: rd_data = {24'h000000, pair_run_reg};
			`OFF_MODE: rd_data = {24'h000000, pair_mode_reg};
			`OFF_LOW_CMP: rd_data = {24'h000000, low_compare_reg};
			`OFF_HIGH_CMP: rd_data = {24'h000000, high_compare_reg};
			`OFF_FFCR: rd_data = {24'h000000, flip_flop_control_reg};
			`OFF_STATUS: rd_data = {15'h0000, output_flip_flop, high_up_counter, low_up_counter};
			`OFF_PORT_DIR: rd_data = {24'h000000, port_direction_reg};
			`OFF_PORT_FUNC: rd_data = {24'h000000, port_function_reg};
			`OFF_DBUF: rd_data = {24'h000000, low_compare_buf_reg};
			default: rd_data = 32'h00000000;
		endcase
	end

	// Pin mux; a registered copy keeps the outputs straight from flip-flops at one cycle of lag.
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			timer_output_pin_o <= 1'b0;
			timer_output_pin_oe_o <= 1'b0;
			high_match_o <= 1'b0;
		end else begin
			// The enable follows the direction bit alone, so the port can drive the pin outside PWM mode too.
			timer_output_pin_oe_o <= port_direction_reg[`PORT_TIMER_BIT];
			if (port_function_reg[`PORT_TIMER_BIT]) begin
				timer_output_pin_o <= pwm_mode ? output_flip_flop : 1'b0;
			end else begin
				timer_output_pin_o <= port_data_i;
			end
			high_match_o <= high_hit;
		end
	end
endmodule

/* File: rtl/pwm_timer_defines.vh */
// Register offsets, field positions and reset values for the paired 8-bit timer in PWM mode.
// Assumes inclusion by the timer module only; definitions only.
`ifndef PWM_TIMER_DEFINES_VH
`define PWM_TIMER_DEFINES_VH
`define OFF_RUN 12'h000
`define OFF_MODE 12'h004
`define OFF_LOW_CMP 12'h008
`define OFF_HIGH_CMP 12'h00c
`define OFF_FFCR 12'h010
`define OFF_STATUS 12'h014
`define OFF_PORT_DIR 12'h018
`define OFF_PORT_FUNC 12'h01c
`define OFF_DBUF 12'h020
`define RUN_LOW_BIT 0
`define RUN_HIGH_BIT 1
`define RUN_PRESCALE_BIT 2
`define RUN_DBUF_BIT 7
`define MODE_SEL_HI 7
`define MODE_SEL_LO 6
`define MODE_PWM 2'h3
`define PERIOD_HI 5
`define PERIOD_LO 4
`define PERIOD_6 2'h1
`define PERIOD_7 2'h2
`define PERIOD_8 2'h3
`define TOP_6 8'h3f
`define TOP_7 8'h7f
`define TOP_8 8'hff
`define HCLK_HI 3
`define HCLK_LO 2
`define LCLK_HI 1
`define LCLK_LO 0
`define FF_CMD_HI 3
`define FF_CMD_LO 2
`define FF_CMD_INVERT 2'h0
`define FF_CMD_SET 2'h1
`define FF_CMD_CLEAR 2'h2
`define FF_TOGGLE_EN_BIT 1
`define PORT_TIMER_BIT 1
`define RESET_BYTE 8'h00
`define RESET_FFCR 8'h0c
`endif

/* File: tb/eight_bit_pwm_timer_mode_tb_top.sv */
// Self-checking bench for pwm_timer in PWM mode.
// Assumes the load model watches the pin and the checker is bound to the design.
`timescale 1ns/1ps
module eight_bit_pwm_timer_mode_tb_top;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic port_data_i = 1'b0;
	logic [31:0] prdata_o, d;
	logic pready_o, pslverr_o, pin_o, oe_o, high_match_o, e;
	int hi_len, lo_len, gap, cyc, last_hm, hm_cnt, n_errors, cmp_count;
	// The div1 tap ticks every fourth clock.
	localparam int TICK = 4;
	always #4 clk_i = ~clk_i;
	pwm_timer DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_clk_i(1'b0), .port_data_i(port_data_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .timer_output_pin_o(pin_o),
		.timer_output_pin_oe_o(oe_o), .high_match_o(high_match_o));
	pwm_load_model load (.clk_i(clk_i), .pin_i(pin_o), .oe_i(oe_o), .hi_len(hi_len), .lo_len(lo_len));
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (high_match_o === 1'b1) begin
			gap <= cyc - last_hm;
			last_hm <= cyc;
			hm_cnt <= hm_cnt + 1;
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, s, x);
		end
	endtask
	// The request is held until pready is seen high, as the bus requires.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rdata,
		output logic er);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1) begin
			@(posedge clk_i);
		end
		rdata = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, d, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0, d, e);
		chk(d, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task automatic t_pwm;
		int top;
		for (int i = 1; i < 4; i++) begin
			top = (1 << (i + 5)) - 1;
			wr(12'h000, 32'h0);
			wr(12'h004, {24'h0, 2'b11, i[1:0], 4'b0101});
			wr(12'h008, 32'h20);
			wr(12'h00c, 32'h4);
			wr(12'h010, 32'h0a);
			wr(12'h018, 32'h2);
			wr(12'h01c, 32'h2);
			wr(12'h000, 32'h87);
			repeat (8 * top + 40) @(posedge clk_i);
			chk(hi_len, (top - 32) * TICK);
			chk(lo_len, 32 * TICK);
			chk(hi_len + lo_len, top * TICK);
			chk(gap, 4 * TICK);
		end
		wr(12'h008, 32'h10);
		rd(12'h008, 32'h20, 1'b0);
		rd(12'h020, 32'h10, 1'b0);
		repeat (2200) @(posedge clk_i);
		chk(hi_len, (255 - 16) * TICK);
		rd(12'h008, 32'h10, 1'b0);
	endtask
	task automatic t_stop;
		logic p;
		wr(12'h000, 32'h0);
		apb(1'b0, 12'h014, 32'h0, d, e);
		chk({24'h0, d[7:0]}, 32'h0);
		p = pin_o;
		repeat (300) @(posedge clk_i);
		chk({31'h0, pin_o}, {31'h0, p});
		wr(12'h010, 32'h06);
		repeat (3) @(posedge clk_i);
		chk({31'h0, pin_o}, 32'h1);
		wr(12'h010, 32'h0a);
		repeat (3) @(posedge clk_i);
		chk({31'h0, pin_o}, 32'h0);
		chk({31'h0, oe_o}, 32'h1);
		port_data_i <= 1'b1;
		wr(12'h01c, 32'h0);
		repeat (3) @(posedge clk_i);
		chk({31'h0, pin_o}, 32'h1);
	endtask
	task automatic t_high_ignore;
		int c0;
		wr(12'h000, 32'h0);
		wr(12'h004, 32'he1);
		wr(12'h00c, 32'h1);
		wr(12'h000, 32'h07);
		c0 = hm_cnt;
		repeat (600) @(posedge clk_i);
		chk(hm_cnt - c0, 32'h0);
	endtask
	task automatic results;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(12'h010, 32'h0c, 1'b0);
		rd(12'h004, 32'h0, 1'b0);
		rd(12'h030, 32'h0, 1'b1);
		t_pwm();
		t_stop();
		t_high_ignore();
		results();
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		n_errors++;
		results();
	end
endmodule

/* File: tb/pwm_load_model.sv */
// Load on the timer pin: keeps the last high and low run lengths in clock cycles.
// Assumes the pin is sampled on the timer clock; runs are dropped while the pin is undriven.
`timescale 1ns/1ps
module pwm_load_model (
	input wire clk_i,
	input wire pin_i,
	input wire oe_i,
	output int hi_len,
	output int lo_len
);
	int run_len = 0;
	logic last = 1'b0;
	always @(posedge clk_i) begin
		last <= pin_i;
		if (oe_i !== 1'b1) begin
			run_len <= 0;
		end else if (pin_i !== last) begin
			run_len <= 1;
			if (last === 1'b1) begin
				hi_len <= run_len;
			end else begin
				lo_len <= run_len;
			end
		end else begin
			run_len <= run_len + 1;
		end
	end
endmodule

/* File: tb/pwm_timer_checker.sv */
// Port assertions for pwm_timer.
// Assumes it is bound to pwm_timer and sees its ports only.
`timescale 1ns/1ps
module pwm_timer_checker (
	input wire clk_i,
	input wire sys_rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire timer_output_pin_oe_o,
	input wire high_match_o
);
	wire dir_wr = psel_i && penable_i && pwrite_i && paddr_i == 12'h018;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	property p_rdy_pulse;
		pready_o |=> !pready_o;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held too long");
	property p_rdy_answer;
		psel_i && penable_i && !pready_o |=> pready_o;
	endproperty
	a_rdy_answer: assert property (p_rdy_answer) else $error("no answer to access");
	property p_rdy_cause;
		pready_o |-> $past(psel_i && penable_i);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access");
	property p_idle_quiet;
		!pready_o |-> prdata_o == 32'h0 && !pslverr_o;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("bus outputs busy when idle");
	property p_err_data;
		pslverr_o |-> prdata_o == 32'h0;
	endproperty
	a_err_data: assert property (p_err_data) else $error("data on refused access");
	property p_upper_zero;
		pready_o && paddr_i != 12'h014 |-> prdata_o[31:8] == 24'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	property p_oe_cause;
		$changed(timer_output_pin_oe_o) |-> $past(dir_wr);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved unasked");
	property p_hm_pulse;
		high_match_o |=> !high_match_o;
	endproperty
	a_hm_pulse: assert property (p_hm_pulse) else $error("match pulse too long");
endmodule
bind pwm_timer pwm_timer_checker u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .timer_output_pin_oe_o(timer_output_pin_oe_o), .high_match_o(high_match_o));
